// >>> pph_ctl_drv.sv
// pph_ctl_drv: registered drivers for the four host control lines
// assumes the caller gives asserted levels; pin low means asserted
`timescale 1ns/1ps

module pph_ctl_drv
    import pph_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic             i_active,
    input  wire logic             i_open_drain,
    input  wire logic [CTL_W-1:0] i_assert,
    output pph_ctl_pins_t         o_pins
);

    pph_ctl_pins_t pins_ff;
    pph_ctl_pins_t nxt_pins;

    ////////////////////////////////////////////////////////////////////////////////
    // R2: open drain or push pull
    always_comb begin
        nxt_pins = '0;
        for (int i = 0; i < CTL_W; i++) begin
            if (!i_active) begin
                nxt_pins.out[i] = 1'b0;
                nxt_pins.oe[i]  = 1'b0;
            end else if (i_open_drain) begin
                // only pull low; the external pull-up gives the high level
                nxt_pins.out[i] = 1'b0;
                nxt_pins.oe[i]  = i_assert[i];
            end else begin
                nxt_pins.out[i] = ~i_assert[i];
                nxt_pins.oe[i]  = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pins_ff <= '0;
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    assign o_pins = pins_ff;

endmodule

// >>> pph_host_port.sv
// pph_host_port: host end of a 1284 parallel port (control, status, data, direction)
// assumes pins are synchronous to i_ref_clk and the strap is stable at reset release
`timescale 1ns/1ps

// Overview of operation
// R1: data held valid while strobe low
// R2: open drain in spp, push pull otherwise
// R3: init pulse low resets link to idle
// R4: select-in low selects the peripheral
// R5: autofeed low requests automatic line feed
// R6: peripheral pulses ack after taking byte
// R7: peripheral holds busy while not ready
// R8: paper end reported, fault also low
// R9: peripheral drives select high when online
// R10: fault low reports peripheral specific error
// R11: data host driven, unused nibble, else bidirectional
// R12: direction output for external transceivers
// R13: active only for the two strap codes
// R14: wait busy low, data steady during strobe
module pph_host_port
    import pph_pkg::*;
#(
    parameter int INIT_CYC = INIT_CYC_DFLT
)(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic [2:0]        i_chip_mode,
    input  pph_mode_t              i_port_mode,
    input  wire logic              i_dir_rev,
    input  wire logic              i_init_req,
    input  wire logic              i_select_req,
    input  wire logic              i_autolf_req,
    input  wire logic              i_tx_valid,
    input  wire logic [DATA_W-1:0] i_tx_data,
    output logic                   o_tx_ready,
    output logic [DATA_W-1:0]      o_rx_data,
    output logic                   o_rx_valid,
    output pph_status_t            o_status,
    output logic                   o_port_active,
    input  wire logic              i_ack_n,
    input  wire logic              i_busy,
    input  wire logic              i_paper_end,
    input  wire logic              i_select,
    input  wire logic              i_fault_n,
    input  wire logic [DATA_W-1:0] i_data_in,
    output logic [DATA_W-1:0]      o_data_out,
    output logic                   o_data_oe,
    output logic                   o_transfer_direction_out,
    output pph_ctl_pins_t          o_ctl
);

    pph_regs_t q_ff;
    pph_regs_t nxt_q;
    logic      ack_fall;

    function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt, input int lim);
        cnt_hit = (cnt == CNT_W'(lim - 1));
    endfunction

    // inbound means the peripheral owns the data lines
    function automatic logic is_inbound(input pph_mode_t mode, input logic rev);
        is_inbound = (mode == PM_NIBBLE) || (rev && (mode == PM_BYTE || mode == PM_ECP));
    endfunction

    assign ack_fall = q_ff.ack_d && !i_ack_n;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_q          = q_ff;
        nxt_q.rx_valid = 1'b0;
        nxt_q.tx_ready = 1'b0;
        nxt_q.ack_d    = i_ack_n;
        // status lines are only mirrored; their meaning belongs to the peripheral
        nxt_q.status.busy      = i_busy;
        nxt_q.status.paper_end = i_paper_end;
        nxt_q.status.online    = i_select;
        nxt_q.status.fault     = !i_fault_n;
        nxt_q.status.ack       = !i_ack_n;
        nxt_q.sel              = i_select_req;
        nxt_q.autolf           = i_autolf_req;

        // R13: strap catch after release
        if (!q_ff.strap_done) begin
            nxt_q.strap_done = 1'b1;
            nxt_q.active     = (i_chip_mode == CHIP_MODE_PP_A) || (i_chip_mode == CHIP_MODE_PP_B);
        end

        case (q_ff.st)
            ST_IDLE: begin
                if (q_ff.tx_ready && i_tx_valid) begin
                    // keep the mode that ready was granted for
                    nxt_q.data = i_tx_data;
                    nxt_q.st   = ST_BUSYW;
                end else begin
                    // mode and direction change only between bytes
                    nxt_q.mode     = i_port_mode;
                    nxt_q.rev      = i_dir_rev;
                    // R11: no byte offered while inbound
                    nxt_q.tx_ready = q_ff.active && !is_inbound(i_port_mode, i_dir_rev) && !i_init_req;
                end
                if (q_ff.dir && q_ff.mode != PM_NIBBLE && ack_fall) begin
                    nxt_q.rx_data  = i_data_in;
                    nxt_q.rx_valid = 1'b1;
                end
            end
            ST_BUSYW: begin
                // R14: wait for busy low
                if (!i_busy) begin
                    nxt_q.st  = ST_SETUP;
                    nxt_q.cnt = '0;
                end
            end
            ST_SETUP: begin
                nxt_q.cnt = q_ff.cnt + 1'b1;
                if (cnt_hit(q_ff.cnt, SETUP_CYC)) begin
                    nxt_q.st     = ST_STROBE;
                    nxt_q.cnt    = '0;
                    nxt_q.strobe = 1'b1;
                end
            end
            ST_STROBE: begin
                // R1: data stays latched
                nxt_q.cnt = q_ff.cnt + 1'b1;
                if (cnt_hit(q_ff.cnt, STROBE_CYC)) begin
                    nxt_q.st     = ST_HOLD;
                    nxt_q.cnt    = '0;
                    nxt_q.strobe = 1'b0;
                end
            end
            ST_HOLD: begin
                nxt_q.cnt = q_ff.cnt + 1'b1;
                if (cnt_hit(q_ff.cnt, HOLD_CYC)) begin
                    nxt_q.st = ST_ACKW;
                end
            end
            ST_ACKW: begin
                // R6: byte done on ack
                if (ack_fall) begin
                    nxt_q.st = ST_IDLE;
                end
            end
            ST_INIT: begin
                nxt_q.cnt = q_ff.cnt + 1'b1;
                if (cnt_hit(q_ff.cnt, INIT_CYC)) begin
                    nxt_q.st   = ST_IDLE;
                    nxt_q.init = 1'b0;
                    nxt_q.mode = PM_SPP;
                end
            end
            default: begin
                nxt_q.st = ST_IDLE;
            end
        endcase

        // R3: init pulse overrides
        // a peripheral that never acks can only be freed this way
        if (q_ff.active && i_init_req && q_ff.st != ST_INIT) begin
            nxt_q.st       = ST_INIT;
            nxt_q.cnt      = '0;
            nxt_q.init     = 1'b1;
            nxt_q.strobe   = 1'b0;
            nxt_q.tx_ready = 1'b0;
            nxt_q.rev      = 1'b0;
        end

        // R12: direction
        nxt_q.dir = is_inbound(nxt_q.mode, nxt_q.rev);
        // R11: data ownership
        nxt_q.data_oe = nxt_q.active && !nxt_q.dir;
        if (!nxt_q.active) begin
            nxt_q.st       = ST_IDLE;
            nxt_q.strobe   = 1'b0;
            nxt_q.init     = 1'b0;
            nxt_q.tx_ready = 1'b0;
            nxt_q.dir      = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            q_ff       <= '0;
            q_ff.st    <= ST_IDLE;
            q_ff.mode  <= PM_SPP;
            q_ff.ack_d <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // R4: select-in, R5: autofeed, R2: driver style
    pph_ctl_drv pph_ctl_drv_inst (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_active     (q_ff.active),
        .i_open_drain (q_ff.mode == PM_SPP),
        .i_assert     ({q_ff.sel, q_ff.init, q_ff.autolf, q_ff.strobe}),
        .o_pins       (o_ctl)
    );

    assign o_tx_ready               = q_ff.tx_ready;
    assign o_rx_data                = q_ff.rx_data;
    assign o_rx_valid               = q_ff.rx_valid;
    assign o_status                 = q_ff.status;
    assign o_port_active            = q_ff.active;
    assign o_data_out               = q_ff.data;
    assign o_data_oe                = q_ff.data_oe;
    assign o_transfer_direction_out = q_ff.dir;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    strobe_data_a: assert property (q_ff.strobe && $past(q_ff.strobe) |-> $stable(o_data_out) && o_data_oe) // R1
        else $error("data moved while strobe asserted");
    od_spp_a: assert property ($past(q_ff.active && q_ff.mode == PM_SPP) |-> o_ctl.out == '0) // R2
        else $error("control line driven high in spp");
    init_hold_a: assert property ($rose(q_ff.init) |-> q_ff.init[*2] ##0 q_ff.st == ST_INIT) // R3
        else $error("init pulse too short");
    select_pin_a: assert property ($past(q_ff.active && q_ff.mode != PM_SPP && q_ff.sel)
                                   |-> o_ctl.oe[CTL_SELIN] && !o_ctl.out[CTL_SELIN]) // R4
        else $error("select-in not driven low");
    autolf_pin_a: assert property ($past(q_ff.active && q_ff.mode == PM_SPP && q_ff.autolf)
                                   |-> o_ctl.oe[CTL_AUTOLF] && !o_ctl.out[CTL_AUTOLF]) // R5
        else $error("autofeed not pulled low");
    nibble_data_a: assert property (q_ff.active && q_ff.mode == PM_NIBBLE |-> !o_data_oe && o_transfer_direction_out) // R11
        else $error("data driven in nibble mode");
    dir_pin_a: assert property (o_data_oe |-> !o_transfer_direction_out) // R12
        else $error("direction disagrees with data drive");
    inactive_a: assert property (q_ff.strap_done && !q_ff.active |=> o_ctl.oe == '0 && !o_data_oe) // R13
        else $error("pins driven while port not selected");
    busy_wait_a: assert property ($rose(q_ff.st == ST_SETUP) |-> !$past(i_busy)) // R14
        else $error("setup started while busy");

endmodule

// >>> pph_host_port_test.sv
// pph_host_port_test: self-checking bench for the parallel host port
// assumes pph_periph_model on the pins and a 200 MHz reference clock
`timescale 1ns/1ps

module pph_host_port_test
    import pph_pkg::*;
;
    logic          clk, rst, valid, init_req, sel_req, alf_req, rev, slow, rev_go;
    logic          ack_n, busy, got_v, tx_ready, rx_v, act, doe, dir, pend, onl, flt_n;
    logic [2:0]    strap;
    pph_mode_t     mode;
    logic [7:0]    txd, rxd, din, dout, got, rbyte, merr;
    pph_status_t   stat;
    pph_ctl_pins_t ctl;
    logic [7:0]    fwd_q[$];
    logic [7:0]    rev_q[$];
    logic [2:0]    straps[4] = '{3'h0, 3'h4, 3'h1, 3'h2};
    int            num_errors, tests_run, seed, n;

    pph_host_port #(.INIT_CYC(16)) pph_host_port_inst (
        .i_ref_clk(clk), .i_rst(rst), .i_chip_mode(strap), .i_port_mode(mode), .i_dir_rev(rev),
        .i_init_req(init_req), .i_select_req(sel_req), .i_autolf_req(alf_req), .i_tx_valid(valid),
        .i_tx_data(txd), .o_tx_ready(tx_ready), .o_rx_data(rxd), .o_rx_valid(rx_v), .o_status(stat),
        .o_port_active(act), .i_ack_n(ack_n), .i_busy(busy), .i_paper_end(pend), .i_select(onl),
        .i_fault_n(flt_n), .i_data_in(din), .o_data_out(dout), .o_data_oe(doe),
        .o_transfer_direction_out(dir), .o_ctl(ctl));

    pph_periph_model pph_periph_model_inst (
        .i_ref_clk(clk), .i_slow(slow), .i_rev_go(rev_go), .i_rev_byte(rbyte), .i_ctl(ctl),
        .i_data_out(dout), .i_data_oe(doe), .o_ack_n(ack_n), .o_busy(busy), .o_data_in(din),
        .o_got_valid(got_v), .o_got_byte(got), .o_err_cnt(merr));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wait_ready;
        int k;
        k = 0;
        while (tx_ready !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 3000) num_errors++;
    endtask

    task automatic send(input logic [7:0] b);
        wait_ready();
        valid = 1'b1;
        txd = b;
        fwd_q.push_back(b);
        @(negedge clk);
        valid = 1'b0;
        wait_ready();
    endtask

    task automatic set_mode(input pph_mode_t m, input logic r);
        mode = m;
        rev = r;
        repeat (4) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    // results noted by the drivers are taken in order as they show up
    always @(negedge clk) begin
        if (got_v === 1'b1) check(got, fwd_q.pop_front());
        if (rx_v === 1'b1) check(rxd, rev_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, valid, init_req, sel_req, alf_req, rev, slow, rev_go} = 8'h80;
        {pend, onl, flt_n} = 3'h1;
        strap = 3'h0;
        mode = PM_SPP;
        txd = 8'h00;
        rbyte = 8'h00;
        num_errors = 0;
        tests_run = 0;
        seed = 1363;
        foreach (straps[i]) begin
            rst = 1'b1;
            strap = straps[i];
            repeat (2) @(negedge clk);
            rst = 1'b0;
            repeat (4) @(negedge clk);
            n = (straps[i] == CHIP_MODE_PP_A || straps[i] == CHIP_MODE_PP_B);
            check({6'h0, act, tx_ready}, {6'h0, n[0], n[0]});
            check({ctl.oe, 3'h0, doe}, {7'h0, n[0]});
        end
        sel_req = 1'b1;
        set_mode(PM_SPP, 1'b0);
        check({ctl.out, ctl.oe}, 8'h08);
        set_mode(PM_ECP, 1'b0);
        check({ctl.out, ctl.oe}, 8'h7f);
        alf_req = 1'b1;
        repeat (3) @(negedge clk);
        check({ctl.out, ctl.oe}, 8'h5f);
        check({7'h0, dir}, 8'h00);
        for (int k = 0; k < 8; k++) begin
            slow = k[1];
            if (k == 4) set_mode(PM_SPP, 1'b0);
            send(8'($random(seed)));
        end
        {sel_req, alf_req} = 2'h0;
        repeat (80) @(negedge clk);
        for (int k = 0; k < 4; k++) begin
            {pend, onl, flt_n} = 3'($random(seed));
            // paper end always comes with fault
            if (pend) flt_n = 1'b0;
            repeat (3) @(negedge clk);
            check({3'h0, stat}, {4'h0, pend, onl, ~flt_n, 1'b0});
        end
        set_mode(PM_NIBBLE, 1'b0);
        check({6'h0, dir, doe}, 8'h02);
        set_mode(PM_BYTE, 1'b1);
        check({6'h0, dir, doe}, 8'h02);
        for (int k = 0; k < 3; k++) begin
            rbyte = 8'($random(seed));
            rev_q.push_back(rbyte);
            rev_go = 1'b1;
            @(negedge clk);
            rev_go = 1'b0;
            repeat (8) @(negedge clk);
        end
        // negotiation keeps the host on the data lines even with reverse asked
        set_mode(PM_NEGOT, 1'b1);
        check({6'h0, dir, doe}, 8'h01);
        set_mode(PM_ECP, 1'b0);
        init_req = 1'b1;
        @(negedge clk);
        init_req = 1'b0;
        n = 0;
        repeat (40) begin
            @(negedge clk);
            if ((ctl.oe[CTL_INIT] ? ctl.out[CTL_INIT] : 1'b1) === 1'b0) n++;
        end
        check(8'(n), 8'h10);
        check(merr, 8'h00);
        report_and_stop();
    end
endmodule

// >>> pph_periph_model.sv
// pph_periph_model: behavioural 1284 peripheral on the far side of the host port pins
// assumes undriven control pins float up and one clock for the whole bench
`timescale 1ns/1ps

module pph_periph_model
    import pph_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_slow,
    input  wire logic              i_rev_go,
    input  wire logic [DATA_W-1:0] i_rev_byte,
    input  pph_ctl_pins_t          i_ctl,
    input  wire logic [DATA_W-1:0] i_data_out,
    input  wire logic              i_data_oe,
    output logic                   o_ack_n,
    output logic                   o_busy,
    output logic [DATA_W-1:0]      o_data_in,
    output logic                   o_got_valid,
    output logic [DATA_W-1:0]      o_got_byte,
    output logic [7:0]             o_err_cnt
);
    logic strobe_lvl;

    assign strobe_lvl = i_ctl.oe[CTL_STROBE] ? i_ctl.out[CTL_STROBE] : 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        o_ack_n = 1'b1;
        o_busy = 1'b0;
        o_data_in = 8'h5a;
        o_got_valid = 1'b0;
        o_got_byte = 8'h00;
        o_err_cnt = 8'h00;
        forever begin
            @(posedge i_ref_clk);
            // released bus keeps changing so a stale value never reads as good
            o_data_in <= ~o_data_in;
            if (strobe_lvl === 1'b0) begin
                // strobe must not start while busy
                if (o_busy) o_err_cnt <= o_err_cnt + 8'h01;
                o_busy <= 1'b1;
                o_got_byte <= i_data_out;
                // data steady and host driven while strobe low
                while (strobe_lvl === 1'b0) begin
                    @(posedge i_ref_clk);
                    if (i_data_out !== o_got_byte || i_data_oe !== 1'b1) o_err_cnt <= o_err_cnt + 8'h01;
                end
                o_got_valid <= 1'b1;
                @(posedge i_ref_clk);
                o_got_valid <= 1'b0;
                repeat (HOLD_CYC + 4) @(posedge i_ref_clk);
                // ack pulse once the byte is taken
                o_ack_n <= 1'b0;
                repeat (5) @(posedge i_ref_clk);
                o_ack_n <= 1'b1;
                // a slow peripheral stays busy well past its ack
                repeat (i_slow ? 60 : 1) @(posedge i_ref_clk);
                o_busy <= 1'b0;
            end else if (i_rev_go) begin
                // reverse byte held across the ack pulse
                o_data_in <= i_rev_byte;
                @(posedge i_ref_clk);
                o_ack_n <= 1'b0;
                repeat (3) @(posedge i_ref_clk);
                o_ack_n <= 1'b1;
            end
        end
    end
endmodule

// >>> pph_pkg.sv
// pph_pkg: shared constants, modes, states and carriers for the parallel host port
// assumes a single 200 MHz reference clock for the whole block
package pph_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // strap codes that give the pins to the parallel port
    localparam logic [2:0] CHIP_MODE_PP_A = 3'h2;
    localparam logic [2:0] CHIP_MODE_PP_B = 3'h1;

    // control line positions; a set bit means the line is asserted (pin low)
    localparam int CTL_W      = 4;
    localparam int CTL_STROBE = 0;
    localparam int CTL_AUTOLF = 1;
    localparam int CTL_INIT   = 2;
    localparam int CTL_SELIN  = 3;

    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // timing, in ns, and derived cycle counts (least times round up)
    localparam int CLK_MHZ     = 200;
    localparam int T_SETUP_NS  = 500;
    localparam int T_STROBE_NS = 500;
    localparam int T_HOLD_NS   = 500;
    localparam int T_INIT_NS   = 50000;
    localparam int SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC  = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC    = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_CYC_DFLT = (T_INIT_NS * CLK_MHZ + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        PM_SPP    = 3'h0,
        PM_NIBBLE = 3'h1,
        PM_BYTE   = 3'h2,
        PM_ECP    = 3'h3,
        PM_NEGOT  = 3'h4
    } pph_mode_t;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_BUSYW  = 7'h02,
        ST_SETUP  = 7'h04,
        ST_STROBE = 7'h08,
        ST_HOLD   = 7'h10,
        ST_ACKW   = 7'h20,
        ST_INIT   = 7'h40
    } pph_state_t;

    // peripheral status, each bit true when the condition holds
    typedef struct packed {
        logic busy;
        logic paper_end;
        logic online;
        logic fault;
        logic ack;
    } pph_status_t;

    typedef struct packed {
        logic [CTL_W-1:0] out;
        logic [CTL_W-1:0] oe;
    } pph_ctl_pins_t;

    typedef struct packed {
        pph_state_t         st;
        logic [CNT_W-1:0]   cnt;
        logic               strap_done;
        logic               active;
        pph_mode_t          mode;
        logic               rev;
        logic               dir;
        logic [DATA_W-1:0]  data;
        logic               data_oe;
        logic               strobe;
        logic               init;
        logic               sel;
        logic               autolf;
        logic               tx_ready;
        logic [DATA_W-1:0]  rx_data;
        logic               rx_valid;
        logic               ack_d;
        pph_status_t        status;
    } pph_regs_t;

endpackage
